// File: logic/ccr_regs.sv
/*
 * APB register bank for channel phase, input, high-pass bypass, offset and gain.
 * Assumes an APB3 master on core_clk; consumers read the struct and value outputs.
 */
// The APB slave port is this design's own decision.
//
// Summary of operation
// - Config bits 15:6 hold a signed 10-bit phase delay in modulator cycles.
// - Config bits 5:3 and bits 7:0 of every low calibration register read zero.
// - Config bit 2 set turns off DC removal for this channel, clear follows the global setting.
// - Config bits 1:0 pick own pins, shorted inputs, positive or negative DC test signal.
// - Offset high register holds bits 23:8 of the signed 24-bit offset.
// - Offset low register holds offset bits 7:0 in its bits 15:8.
// - Gain high register holds bits 23:8 of the unsigned 24-bit gain in 0 to below 2.0.
// - Gain low register holds gain bits 7:0 in its bits 15:8.
// - The preceding channel's gain low register uses the same layout and resets to zero.
// - Gain high resets to 8000h for unity gain; all other registers reset to zero.
// - Registers sit at word indices 18h to 1Ch, preceding channel gain low at 17h, next channel config at 1Dh.
`timescale 1ns/100ps
module ccr_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ccr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output ccr_pkg::ccr_chan_cfg_t chan3_cfg,
    output ccr_pkg::ccr_chan_cfg_t chan4_cfg,
    output logic signed [23:0] chan3_offset,
    output logic [23:0] chan3_gain,
    output logic [7:0] chan2_gain_lower
);
    import ccr_pkg::*;

    logic [DATA_W-1:0] reg_q [NUM_REGS];
    logic [DATA_W-1:0] last_wdata;
    logic first_cycle;

    // Address decode
    wire logic [5:0] word_idx = paddr[APB_AW-1:2];
    wire logic aligned = (paddr[1:0] == 2'h0);
    wire logic addr_hit = aligned && (word_idx >= IDX_FIRST) && (word_idx <= IDX_LAST);
    wire logic [5:0] idx_diff = word_idx - IDX_FIRST;
    wire logic [SEL_W-1:0] reg_sel = idx_diff[SEL_W-1:0];
    wire logic setup_phase = psel && !penable;
    wire logic access_done = psel && penable && pready;
    wire logic wr_fire = access_done && pwrite && !pslverr;
    wire logic [DATA_W-1:0] rd_word = addr_hit ? reg_q[reg_sel] : RESET_ZERO;
    wire logic [31:0] next_prdata = {16'h0000, rd_word};
    wire logic next_pready = setup_phase;
    wire logic next_pslverr = setup_phase && !addr_hit;

    // Register array, one masked register per slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            wire logic wr_this = wr_fire && addr_hit && (reg_sel == SEL_W'(gi));
            ccr_field_reg #(
                .RESET_VAL(REG_RESET[gi]),
                .WR_MASK(REG_MASK[gi])
            ) u_reg (
                .core_clk(core_clk),
                .rstn(rstn),
                .wr_en(wr_this),
                .wdata(pwdata[DATA_W-1:0]),
                .q(reg_q[gi])
            );
        end
    endgenerate

    // Bus answer: read data and error caught in setup, ready in access
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            if (setup_phase) begin
                prdata <= next_prdata;
            end
        end
    end

    // Channel fields
    assign chan3_cfg.phase_adjust = reg_q[SEL_CHAN3_CONFIG][PHASE_MSB:PHASE_LSB];
    assign chan3_cfg.highpass_bypass = reg_q[SEL_CHAN3_CONFIG][BYPASS_BIT];
    assign chan3_cfg.input_select = ccr_input_sel_t'(reg_q[SEL_CHAN3_CONFIG][INSEL_MSB:INSEL_LSB]);
    assign chan4_cfg.phase_adjust = reg_q[SEL_CHAN4_CONFIG][PHASE_MSB:PHASE_LSB];
    assign chan4_cfg.highpass_bypass = reg_q[SEL_CHAN4_CONFIG][BYPASS_BIT];
    assign chan4_cfg.input_select = ccr_input_sel_t'(reg_q[SEL_CHAN4_CONFIG][INSEL_MSB:INSEL_LSB]);
    // Offset joined from high and low halves
    assign chan3_offset = {reg_q[SEL_CHAN3_OFFSET_HIGH], reg_q[SEL_CHAN3_OFFSET_LOW][LOWER_MSB:LOWER_LSB]};
    // Gain joined from high and low halves
    assign chan3_gain = {reg_q[SEL_CHAN3_GAIN_HIGH], reg_q[SEL_CHAN3_GAIN_LOW][LOWER_MSB:LOWER_LSB]};
    assign chan2_gain_lower = reg_q[SEL_CHAN2_GAIN_LOW][LOWER_MSB:LOWER_LSB];

    // Helpers for checking
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            last_wdata <= 16'h0000;
            first_cycle <= 1'b1;
        end else begin
            last_wdata <= pwdata[DATA_W-1:0];
            first_cycle <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_wr(logic [APB_AW-1:0] a);
        psel && !penable && pwrite && paddr == a ##1 psel && penable && pready && pwrite && paddr == a;
    endsequence

    sequence s_rd(logic [APB_AW-1:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable && pready && !pwrite && paddr == a;
    endsequence

    a_phase_field: assert property (s_wr(ADDR_CHAN3_CONFIG) |=>
        chan3_cfg.phase_adjust == last_wdata[PHASE_MSB:PHASE_LSB])
        else $error("Phase adjust not loaded from write");

    a_cfg_reserved_read: assert property (s_rd(ADDR_CHAN3_CONFIG) |->
        prdata[RSVD_CFG_MSB:RSVD_CFG_LSB] == 3'h0 && prdata[31:DATA_W] == 16'h0000)
        else $error("Config reserved bits read nonzero");

    a_bypass_bit: assert property (s_wr(ADDR_CHAN3_CONFIG) |=>
        chan3_cfg.highpass_bypass == last_wdata[BYPASS_BIT])
        else $error("High-pass bypass not loaded");

    a_input_select: assert property (s_wr(ADDR_CHAN3_CONFIG) |=>
        chan3_cfg.input_select == last_wdata[INSEL_MSB:INSEL_LSB])
        else $error("Input select not loaded");

    a_offset_upper: assert property (s_wr(ADDR_CHAN3_OFFSET_HIGH) |=>
        chan3_offset[23:8] == last_wdata && $stable(chan3_offset[7:0]))
        else $error("Offset upper bits wrong");

    a_offset_lower: assert property (s_wr(ADDR_CHAN3_OFFSET_LOW) |=>
        chan3_offset[7:0] == last_wdata[LOWER_MSB:LOWER_LSB] && $stable(chan3_offset[23:8]))
        else $error("Offset lower bits wrong");

    a_gain_upper: assert property (s_wr(ADDR_CHAN3_GAIN_HIGH) |=>
        chan3_gain[23:8] == last_wdata && $stable(chan3_gain[7:0]))
        else $error("Gain upper bits wrong");

    a_gain_lower: assert property (s_wr(ADDR_CHAN3_GAIN_LOW) |=>
        chan3_gain[7:0] == last_wdata[LOWER_MSB:LOWER_LSB])
        else $error("Gain lower bits wrong");

    a_prev_gain_lower: assert property (s_wr(ADDR_CHAN2_GAIN_LOW) ##1 s_rd(ADDR_CHAN2_GAIN_LOW) |->
        prdata[LOWER_MSB:LOWER_LSB] == chan2_gain_lower && prdata[RSVD_LOW_MSB:RSVD_LOW_LSB] == 8'h00)
        else $error("Preceding channel gain lower readback wrong");

    a_reset_values: assert property (first_cycle |->
        chan3_gain == {RESET_GAIN_HIGH, 8'h00} && chan3_offset == 24'sh000000 && chan2_gain_lower == 8'h00)
        else $error("Reset values wrong");

    a_addr_decode: assert property (s_rd(ADDR_CHAN3_GAIN_HIGH) |->
        prdata[DATA_W-1:0] == chan3_gain[23:8] && !pslverr)
        else $error("Gain high not decoded at its address");

    a_reserved_write: assert property (s_wr(ADDR_CHAN3_GAIN_LOW) ##1 s_rd(ADDR_CHAN3_GAIN_LOW) |->
        prdata[RSVD_LOW_MSB:RSVD_LOW_LSB] == 8'h00)
        else $error("Reserved low byte took a write");

    a_unmapped_error: assert property (psel && !penable && !addr_hit |=> pslverr && pready && prdata == 32'h0)
        else $error("Unmapped access not flagged");

    sequence s_err_wr;
        psel && !penable && pwrite && !addr_hit ##1 psel && penable && pready;
    endsequence

    a_ready_after_setup: assert property (setup_phase |=>
        pready)
        else $error("Ready missing after setup");

    a_no_ready_idle: assert property (!setup_phase |=>
        !pready)
        else $error("Ready without setup");

    a_ready_one_cycle: assert property (pready |=>
        !pready)
        else $error("Ready held too long");

    a_err_with_ready: assert property (pslverr |->
        pready)
        else $error("Error without ready");

    a_mapped_no_err: assert property (setup_phase && addr_hit |=>
        !pslverr)
        else $error("Error on mapped address");

    a_misaligned_err: assert property (setup_phase && !aligned |=>
        pslverr && prdata == 32'h0)
        else $error("Misaligned access not flagged");

    a_rdata_hold: assert property (!setup_phase |=>
        $stable(prdata))
        else $error("Read data changed outside setup");

    a_rdata_upper_zero: assert property (pready |->
        prdata[31:DATA_W] == 16'h0000)
        else $error("Upper read data nonzero");

    a_chan4_rsvd_read: assert property (s_rd(ADDR_CHAN4_CONFIG) |->
        prdata[RSVD_CFG_MSB:RSVD_CFG_LSB] == 3'h0)
        else $error("Next channel reserved bits nonzero");

    a_offset_rsvd_read: assert property (s_rd(ADDR_CHAN3_OFFSET_LOW) |->
        prdata[RSVD_LOW_MSB:RSVD_LOW_LSB] == 8'h00)
        else $error("Offset low reserved byte nonzero");

    a_gain_rsvd_read: assert property (s_rd(ADDR_CHAN3_GAIN_LOW) |->
        prdata[RSVD_LOW_MSB:RSVD_LOW_LSB] == 8'h00)
        else $error("Gain low reserved byte nonzero");

    a_chan2_rsvd_read: assert property (s_rd(ADDR_CHAN2_GAIN_LOW) |->
        prdata[RSVD_LOW_MSB:RSVD_LOW_LSB] == 8'h00)
        else $error("Preceding gain reserved byte nonzero");

    a_cfg_phase_read: assert property (s_rd(ADDR_CHAN3_CONFIG) |->
        prdata[PHASE_MSB:PHASE_LSB] == chan3_cfg.phase_adjust)
        else $error("Phase readback wrong");

    a_cfg_mode_read: assert property (s_rd(ADDR_CHAN3_CONFIG) |->
        prdata[BYPASS_BIT] == chan3_cfg.highpass_bypass && prdata[INSEL_MSB:INSEL_LSB] == chan3_cfg.input_select)
        else $error("Mode readback wrong");

    a_chan4_phase_read: assert property (s_rd(ADDR_CHAN4_CONFIG) |->
        prdata[PHASE_MSB:PHASE_LSB] == chan4_cfg.phase_adjust)
        else $error("Next channel phase readback wrong");

    a_offset_high_read: assert property (s_rd(ADDR_CHAN3_OFFSET_HIGH) |->
        prdata[DATA_W-1:0] == chan3_offset[23:8])
        else $error("Offset high readback wrong");

    a_offset_low_read: assert property (s_rd(ADDR_CHAN3_OFFSET_LOW) |->
        prdata[LOWER_MSB:LOWER_LSB] == chan3_offset[7:0])
        else $error("Offset low readback wrong");

    a_gain_low_read: assert property (s_rd(ADDR_CHAN3_GAIN_LOW) |->
        prdata[LOWER_MSB:LOWER_LSB] == chan3_gain[7:0])
        else $error("Gain low readback wrong");

    a_chan2_read: assert property (s_rd(ADDR_CHAN2_GAIN_LOW) |->
        prdata[LOWER_MSB:LOWER_LSB] == chan2_gain_lower)
        else $error("Preceding gain readback wrong");

    a_chan4_phase_write: assert property (s_wr(ADDR_CHAN4_CONFIG) |=>
        chan4_cfg.phase_adjust == last_wdata[PHASE_MSB:PHASE_LSB])
        else $error("Next channel phase not loaded");

    a_chan4_bypass_write: assert property (s_wr(ADDR_CHAN4_CONFIG) |=>
        chan4_cfg.highpass_bypass == last_wdata[BYPASS_BIT])
        else $error("Next channel bypass not loaded");

    a_chan4_insel_write: assert property (s_wr(ADDR_CHAN4_CONFIG) |=>
        chan4_cfg.input_select == last_wdata[INSEL_MSB:INSEL_LSB])
        else $error("Next channel input select not loaded");

    a_chan2_write: assert property (s_wr(ADDR_CHAN2_GAIN_LOW) |=>
        chan2_gain_lower == last_wdata[LOWER_MSB:LOWER_LSB])
        else $error("Preceding gain lower not loaded");

    a_gain_high_kept: assert property (s_wr(ADDR_CHAN3_GAIN_LOW) |=>
        $stable(chan3_gain[23:8]))
        else $error("Gain high moved on low write");

    a_chan2_kept: assert property (s_wr(ADDR_CHAN3_GAIN_LOW) |=>
        $stable(chan2_gain_lower))
        else $error("Preceding gain moved on own gain write");

    a_chan4_kept: assert property (s_wr(ADDR_CHAN3_CONFIG) |=>
        $stable(chan4_cfg))
        else $error("Next channel config moved");

    a_refused_write: assert property (s_err_wr |=>
        $stable({chan3_cfg, chan4_cfg, chan3_offset, chan3_gain, chan2_gain_lower}))
        else $error("Refused write changed a register");

    a_idle_hold: assert property (!wr_fire |=>
        $stable({chan3_cfg, chan4_cfg, chan3_offset, chan3_gain, chan2_gain_lower}))
        else $error("Register changed without a write");

    a_read_no_change: assert property (psel && penable && !pwrite |=>
        $stable({chan3_cfg, chan4_cfg, chan3_offset, chan3_gain, chan2_gain_lower}))
        else $error("Read changed a register");

    a_reset_fields: assert property (first_cycle |->
        chan3_cfg == '0 && chan4_cfg == '0)
        else $error("Config reset values wrong");

    a_reset_bus: assert property (first_cycle |->
        !pready && !pslverr && prdata == 32'h0)
        else $error("Bus outputs not idle after reset");

endmodule

// File: logic/ccr_pkg.sv
/*
 * Constants and types for the channel calibration and configuration bank.
 * Assumes a 16-bit register per 32-bit APB word, byte address = index * 4.
 */
package ccr_pkg;

    localparam int NUM_REGS = 7;
    localparam int DATA_W = 16;
    localparam int APB_AW = 8;
    localparam int SEL_W = 3;

    // Register indices
    localparam logic [5:0] IDX_CHAN2_GAIN_LOW = 6'h17;
    localparam logic [5:0] IDX_CHAN3_CONFIG = 6'h18;
    localparam logic [5:0] IDX_CHAN3_OFFSET_HIGH = 6'h19;
    localparam logic [5:0] IDX_CHAN3_OFFSET_LOW = 6'h1a;
    localparam logic [5:0] IDX_CHAN3_GAIN_HIGH = 6'h1b;
    localparam logic [5:0] IDX_CHAN3_GAIN_LOW = 6'h1c;
    localparam logic [5:0] IDX_CHAN4_CONFIG = 6'h1d;
    localparam logic [5:0] IDX_FIRST = IDX_CHAN2_GAIN_LOW;
    localparam logic [5:0] IDX_LAST = IDX_CHAN4_CONFIG;

    // Byte addresses
    localparam logic [APB_AW-1:0] ADDR_CHAN2_GAIN_LOW = {IDX_CHAN2_GAIN_LOW, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN3_CONFIG = {IDX_CHAN3_CONFIG, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN3_OFFSET_HIGH = {IDX_CHAN3_OFFSET_HIGH, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN3_OFFSET_LOW = {IDX_CHAN3_OFFSET_LOW, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN3_GAIN_HIGH = {IDX_CHAN3_GAIN_HIGH, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN3_GAIN_LOW = {IDX_CHAN3_GAIN_LOW, 2'h0};
    localparam logic [APB_AW-1:0] ADDR_CHAN4_CONFIG = {IDX_CHAN4_CONFIG, 2'h0};

    // Slots in the register array
    localparam logic [SEL_W-1:0] SEL_CHAN2_GAIN_LOW = 3'h0;
    localparam logic [SEL_W-1:0] SEL_CHAN3_CONFIG = 3'h1;
    localparam logic [SEL_W-1:0] SEL_CHAN3_OFFSET_HIGH = 3'h2;
    localparam logic [SEL_W-1:0] SEL_CHAN3_OFFSET_LOW = 3'h3;
    localparam logic [SEL_W-1:0] SEL_CHAN3_GAIN_HIGH = 3'h4;
    localparam logic [SEL_W-1:0] SEL_CHAN3_GAIN_LOW = 3'h5;
    localparam logic [SEL_W-1:0] SEL_CHAN4_CONFIG = 3'h6;

    // Reset values
    localparam logic [DATA_W-1:0] RESET_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] RESET_GAIN_HIGH = 16'h8000;

    // Writable bit masks; cleared bits are reserved and read zero
    localparam logic [DATA_W-1:0] MASK_CONFIG = 16'hffc7;
    localparam logic [DATA_W-1:0] MASK_FULL = 16'hffff;
    localparam logic [DATA_W-1:0] MASK_LOWER = 16'hff00;

    localparam logic [DATA_W-1:0] REG_RESET [NUM_REGS] = '{
        RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_ZERO, RESET_GAIN_HIGH, RESET_ZERO, RESET_ZERO};
    localparam logic [DATA_W-1:0] REG_MASK [NUM_REGS] = '{
        MASK_LOWER, MASK_CONFIG, MASK_FULL, MASK_LOWER, MASK_FULL, MASK_LOWER, MASK_CONFIG};

    // Field positions
    localparam int PHASE_MSB = 15;
    localparam int PHASE_LSB = 6;
    localparam int RSVD_CFG_MSB = 5;
    localparam int RSVD_CFG_LSB = 3;
    localparam int BYPASS_BIT = 2;
    localparam int INSEL_MSB = 1;
    localparam int INSEL_LSB = 0;
    localparam int LOWER_MSB = 15;
    localparam int LOWER_LSB = 8;
    localparam int RSVD_LOW_MSB = 7;
    localparam int RSVD_LOW_LSB = 0;

    typedef enum logic [1:0] {
        CCR_INSEL_PINS = 2'h0,
        CCR_INSEL_SHORTED = 2'h1,
        CCR_INSEL_TEST_POS = 2'h2,
        CCR_INSEL_TEST_NEG = 2'h3
    } ccr_input_sel_t;

    typedef struct packed {
        logic signed [9:0] phase_adjust;
        logic highpass_bypass;
        ccr_input_sel_t input_select;
    } ccr_chan_cfg_t;

endpackage

// File: logic/ccr_field_reg.sv
/*
 * One 16-bit register with a constant reset value and a writable-bit mask.
 * Assumes write enable already qualified by the bus decode.
 */
`timescale 1ns/100ps
module ccr_field_reg #(
    parameter logic [15:0] RESET_VAL = 16'h0000,
    parameter logic [15:0] WR_MASK = 16'hffff
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    output logic [15:0] q
);

    // Masked bits never load, so they stay zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= RESET_VAL & WR_MASK;
        end else if (wr_en) begin
            q <= wdata & WR_MASK;
        end
    end

endmodule

// File: test/ccr_regs_test.sv
/*
 * Self-checking bench for the channel calibration register bank over APB.
 * Assumes zero-wait APB answers and package byte addresses; bench drives all DUT inputs.
 */
`timescale 1ns/100ps
module ccr_regs_test;
    import ccr_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] rst;
        logic [31:0] wd;
        logic [15:0] rd;
    } ccr_row_t;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    ccr_chan_cfg_t chan3_cfg, chan4_cfg;
    logic signed [23:0] chan3_offset;
    logic [23:0] chan3_gain;
    logic [7:0] chan2_gain_lower;
    logic [1:0] s;
    int miscompares = 0;
    int samples_checked = 0;
    ccr_row_t rows [7];

    ccr_regs dut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan3_cfg(chan3_cfg), .chan4_cfg(chan4_cfg), .chan3_offset(chan3_offset),
        .chan3_gain(chan3_gain), .chan2_gain_lower(chan2_gain_lower));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task chk_data(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // One APB transfer; keep leaves the bus selected for a back-to-back setup
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic keep);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        chk_data(n, 32'h1, "access cycles");
        rd = prdata;
        err = pslverr;
        if (!keep) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge core_clk);
        end
    endtask

    task summarize();
        $display("checked %0d samples, %0d miscompares", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        miscompares++;
        summarize();
    end

    initial begin
        rows = '{'{ADDR_CHAN3_CONFIG, 16'h0000, 32'hffffffff, 16'hffc7},
            '{ADDR_CHAN3_OFFSET_HIGH, 16'h0000, 32'h0000a5c3, 16'ha5c3},
            '{ADDR_CHAN3_OFFSET_LOW, 16'h0000, 32'h0000ffff, 16'hff00},
            '{ADDR_CHAN3_GAIN_HIGH, 16'h8000, 32'h00001234, 16'h1234},
            '{ADDR_CHAN3_GAIN_LOW, 16'h0000, 32'h000056ab, 16'h5600},
            '{ADDR_CHAN2_GAIN_LOW, 16'h0000, 32'h0000beef, 16'hbe00},
            '{ADDR_CHAN4_CONFIG, 16'h0000, 32'h00008075, 16'h8045}};
        rstn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= '0;
        pwdata <= '0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        chk_data({8'h00, chan3_gain}, 32'h00800000, "gain reset");
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0, 1'b0);
            chk_data(rd, {16'h0, rows[i].rst}, "reset read");
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wd, 1'b0);
            apb(1'b0, rows[i].addr, 32'h0, 1'b0);
            chk_data(rd, {16'h0, rows[i].rd}, "readback");
            chk_bit(err, 1'b0, "mapped error");
        end
        chk_data({8'h00, chan3_offset}, 32'h00a5c3ff, "offset out");
        chk_data({8'h00, chan3_gain}, 32'h00123456, "gain out");
        chk_data({24'h0, chan2_gain_lower}, 32'h000000be, "chan2 gain out");
        chk_data({19'h0, chan4_cfg}, {19'h0, 10'h201, 1'b1, 2'b01}, "chan4 cfg out");
        for (int k = 0; k < 4; k++) begin
            s = k[1:0];
            apb(1'b1, ADDR_CHAN3_CONFIG, {16'hffff, 8'h80, s, 3'b111, s[1], s}, 1'b0);
            chk_data({19'h0, chan3_cfg}, {19'h0, 8'h80, s, s[1], s}, "cfg fields");
        end
        apb(1'b0, 8'h78, 32'h0, 1'b0);
        chk_bit(err, 1'b1, "unmapped error");
        chk_data(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h61, 32'h0000ffff, 1'b0);
        chk_bit(err, 1'b1, "misaligned error");
        apb(1'b0, ADDR_CHAN3_CONFIG, 32'h0, 1'b0);
        chk_data(rd, 32'h000080c7, "cfg kept");
        apb(1'b1, ADDR_CHAN3_GAIN_LOW, 32'h0000a5ff, 1'b1);
        apb(1'b0, ADDR_CHAN3_GAIN_LOW, 32'h0, 1'b0);
        chk_data(rd, 32'h0000a500, "back to back");
        chk_data({8'h00, chan3_gain}, 32'h001234a5, "gain low out");
        apb(1'b1, ADDR_CHAN2_GAIN_LOW, 32'h00001234, 1'b1);
        apb(1'b0, ADDR_CHAN2_GAIN_LOW, 32'h0, 1'b0);
        chk_data(rd, 32'h00001200, "chan2 back to back");
        chk_data({24'h0, chan2_gain_lower}, 32'h00000012, "chan2 gain out");
        rstn <= 1'b0;
        @(posedge core_clk);
        chk_data({8'h00, chan3_gain}, 32'h00800000, "gain mid reset");
        chk_data({8'h00, chan3_offset}, 32'h0, "offset mid reset");
        chk_data({19'h0, chan3_cfg}, 32'h0, "cfg mid reset");
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, ADDR_CHAN3_GAIN_HIGH, 32'h0, 1'b0);
        chk_data(rd, 32'h00008000, "gain high after reset");
        chk_bit(err, 1'b0, "error after reset");
        summarize();
    end
endmodule
